// File: design/lbm_pkg.sv
// Package for the local-bus master address-phase signalling block.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
package lbm_pkg;

  // ------------------------------------------------------------------
  // Widths and encodings
  // ------------------------------------------------------------------
  localparam int BUS_W      = 32;        // Muxed address/data width
  localparam int FIFO_DEPTH = 8;         // Request FIFO depth
  localparam int CNT_LSB    = 0;         // Transfer-count field position
  localparam int CNT_W      = 2;         // Transfer-count field width
  localparam int WADDR_LSB  = 2;         // Word address position
  localparam logic [3:0] BE_NONE = 4'h0; // No lanes enabled
  localparam logic [31:0] BUS_RST = 32'h0000_0000; // Bus reset value
  localparam logic [31:0] FILL_LVL = 32'h0000_0000; // Unused-lane level

  // Bus request from the core side
  typedef struct packed {
    logic [31:0] addr;   // Physical byte address
    logic        write;  // 1 = write
    logic [1:0]  beats;  // Transfers minus one
    logic [3:0]  be;     // Byte lanes carrying data (active high)
    logic [31:0] wdata;  // Write data for all beats
  } lbm_req_s;

  // Bus phase
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_DATA,
    PH_HOLD
  } lbm_phase_e;

endpackage

// File: design/lbm_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset, shared clock enable.
`timescale 1ns/1ps
module lbm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  // ------------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];      // Word storage
  logic [AW-1:0]    wp_q, wp_d;         // Write pointer
  logic [AW-1:0]    rp_q, rp_d;         // Read pointer
  logic [AW:0]      cnt_q, cnt_d;       // Fill level
  logic             push, pop;          // Handshakes

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Next pointer and level values
  always_comb begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

endmodule

// File: design/lbm_master.sv
// Local-bus master: address cycle, data beats, hold and halt behaviour.
// Assumes requests come from logic on clk_i; ready, hold and halt arrive
// from pins and are synchronised here.
`timescale 1ns/1ps
module lbm_master (
  // Clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  // Core request stream
  input  wire logic                req_valid_i,
  output logic                     req_ready_o,
  input  wire lbm_pkg::lbm_req_s   req_i,
  // Read data return
  output logic                     rd_valid_o,
  output logic [31:0]              rd_data_o,
  // Control pins
  input  wire logic                local_wait_ready_n_i,
  input  wire logic                memctl_ready_return_n_i,
  input  wire logic                hold_req_i,
  input  wire logic                halt_req_i,
  output logic                     hold_ack_o,
  // Multiplexed bus pins
  input  wire logic [31:0]         muxed_addr_data_bus_i,
  output logic [31:0]              muxed_addr_data_bus_o,
  output logic                     muxed_addr_data_bus_oe_o,
  // Strobes
  output logic                     addr_strobe_n_o,
  output logic                     addr_strobe_n_oe_o,
  output logic                     addr_latch_en_o,
  output logic                     addr_latch_en_oe_o,
  output logic                     final_beat_n_o,
  output logic                     final_beat_n_oe_o
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [3:0] sy1_q, sy2_q;             // Two-stage sync of control pins
  logic       rdy, hold_rq, halt_rq;    // Synchronised levels
  logic [31:0] din1_q, din2_q;          // Two-stage sync of read data

  // Sampling stages only; first stage feeds nothing but the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sy1_q  <= 4'hF;
      sy2_q  <= 4'hF;
      din1_q <= lbm_pkg::BUS_RST;
      din2_q <= lbm_pkg::BUS_RST;
    end else if (ce_i) begin
      sy1_q  <= {local_wait_ready_n_i, memctl_ready_return_n_i,
                 ~hold_req_i, ~halt_req_i};
      sy2_q  <= sy1_q;
      din1_q <= muxed_addr_data_bus_i;
      din2_q <= din1_q;
    end
  end

  // Either ready input ends a beat
  assign rdy     = !sy2_q[3] || !sy2_q[2];
  assign hold_rq = !sy2_q[1];
  assign halt_rq = !sy2_q[0];

  // ------------------------------------------------------------------
  // Request FIFO
  // ------------------------------------------------------------------
  localparam int REQ_W = $bits(lbm_pkg::lbm_req_s);
  logic              f_valid, f_ready;  // Drain handshake
  logic [REQ_W-1:0]  f_data;            // Drained word
  lbm_pkg::lbm_req_s cur;               // Head request

  lbm_fifo #(
    .WIDTH (REQ_W),
    .DEPTH (lbm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .in_data_i   (req_i),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  assign cur = lbm_pkg::lbm_req_s'(f_data);

  // ------------------------------------------------------------------
  // Bus sequencer state
  // ------------------------------------------------------------------
  lbm_pkg::lbm_phase_e ph_q, ph_d;      // Bus phase
  logic [1:0]  left_q, left_d;          // Transfers still to go, minus one
  logic [31:0] bus_q, bus_d;            // Driven bus value
  logic        bus_oe_q, bus_oe_d;      // Bus driver enable
  logic        ads_n_q, ads_n_d;        // Address strobe
  logic        ale_q, ale_d;            // Latch enable
  logic        ale_oe_q, ale_oe_d;      // Latch enable driver
  logic        final_beat_n_n_q, final_beat_n_n_d;    // Final beat indicator
  logic        ctl_oe_q, ctl_oe_d;      // Strobe/final beat drivers
  logic        hack_q, hack_d;          // Hold acknowledge
  logic        rdv_q, rdv_d;            // Read data valid pulse
  logic [31:0] rdd_q, rdd_d;            // Read data
  logic        pop;                     // Request retired

  assign f_ready = pop;

  // Lane fill: data lanes carry write data, others a fixed level
  function automatic logic [31:0] lane_mux(input logic [31:0] d,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = lbm_pkg::FILL_LVL;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Next-state and output computation
  always_comb begin
    ph_d      = ph_q;
    left_d    = left_q;
    bus_d     = bus_q;
    bus_oe_d  = bus_oe_q;
    ads_n_d   = 1'b1;
    ale_d     = 1'b0;
    ale_oe_d  = ale_oe_q;
    final_beat_n_n_d = final_beat_n_n_q;
    ctl_oe_d  = ctl_oe_q;
    hack_d    = hack_q;
    rdv_d     = 1'b0;
    rdd_d     = rdd_q;
    pop       = 1'b0;
    case (ph_q)
      lbm_pkg::PH_IDLE: begin
        final_beat_n_n_d = 1'b1;
        if (hold_rq) begin
          // Release every driver while another master owns the bus
          ph_d     = lbm_pkg::PH_HOLD;
          bus_oe_d = 1'b0;
          ctl_oe_d = 1'b0;
          ale_oe_d = 1'b0;
          hack_d   = 1'b1;
        end else if (halt_rq) begin
          // Halted: bus keeps its last value, including count bits
          bus_oe_d = 1'b1;
        end else if (f_valid) begin
          ph_d     = lbm_pkg::PH_ADDR;
          bus_oe_d = 1'b1;
          ctl_oe_d = 1'b1;
          ale_oe_d = 1'b1;
          ads_n_d  = 1'b0;
          ale_d    = 1'b1;
          bus_d    = {cur.addr[31:lbm_pkg::WADDR_LSB],
                      cur.beats};
          left_d   = cur.beats;
        end
      end
      lbm_pkg::PH_ADDR: begin
        // First data cycle: strobe and latch enable already released
        ph_d      = lbm_pkg::PH_DATA;
        final_beat_n_n_d = (left_q != 2'h0);
        if (cur.write) begin
          bus_d = lane_mux(cur.wdata, cur.be);
        end else begin
          bus_oe_d = 1'b0;
          // Read keeps the address for a later halt
        end
      end
      lbm_pkg::PH_DATA: begin
        if (rdy) begin
          if (!cur.write) begin
            rdv_d = 1'b1;
            rdd_d = din2_q;
          end
          if (left_q == 2'h0) begin
            ph_d      = lbm_pkg::PH_IDLE;
            final_beat_n_n_d = 1'b1;
            pop       = 1'b1;
            bus_oe_d  = 1'b1;
            // Upper lines keep the last value on the bus: the lane
            // data after a write, the address after a read
            // Count bits return so a later halt shows the last size
            bus_d     = {bus_q[31:lbm_pkg::WADDR_LSB], cur.beats};
          end else begin
            left_d    = left_q - 2'h1;
            final_beat_n_n_d = (left_q != 2'h1);
          end
        end
        // Without ready the indicator holds its level (wait states)
      end
      lbm_pkg::PH_HOLD: begin
        if (!hold_rq) begin
          ph_d     = lbm_pkg::PH_IDLE;
          bus_oe_d = 1'b1;
          ctl_oe_d = 1'b1;
          ale_oe_d = 1'b1;
          hack_d   = 1'b0;
        end
      end
      default: begin
        ph_d = lbm_pkg::PH_IDLE;
      end
    endcase
  end

  // Sequencer registers; reset floats bus, strobe high, latch low
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ph_q      <= lbm_pkg::PH_IDLE;
      left_q    <= 2'h0;
      bus_q     <= lbm_pkg::BUS_RST;
      bus_oe_q  <= 1'b0;
      ads_n_q   <= 1'b1;
      ale_q     <= 1'b0;
      ale_oe_q  <= 1'b1;
      final_beat_n_n_q <= 1'b1;
      ctl_oe_q  <= 1'b1;
      hack_q    <= 1'b0;
      rdv_q     <= 1'b0;
      rdd_q     <= lbm_pkg::BUS_RST;
    end else if (ce_i) begin
      ph_q      <= ph_d;
      left_q    <= left_d;
      bus_q     <= bus_d;
      bus_oe_q  <= bus_oe_d;
      ads_n_q   <= ads_n_d;
      ale_q     <= ale_d;
      ale_oe_q  <= ale_oe_d;
      final_beat_n_n_q <= final_beat_n_n_d;
      ctl_oe_q  <= ctl_oe_d;
      hack_q    <= hack_d;
      rdv_q     <= rdv_d;
      rdd_q     <= rdd_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs straight from flip-flops, except the final beat enable, decoded from ctl_oe_q and ph_q
  // ------------------------------------------------------------------
  assign muxed_addr_data_bus_o    = bus_q;
  assign muxed_addr_data_bus_oe_o = bus_oe_q;
  assign addr_strobe_n_o          = ads_n_q;
  assign addr_strobe_n_oe_o       = ctl_oe_q;
  assign addr_latch_en_o          = ale_q;
  assign addr_latch_en_oe_o       = ale_oe_q;
  assign final_beat_n_o           = final_beat_n_n_q;
  // Final beat driver stays off in reset so the pull-up holds it high
  assign final_beat_n_oe_o        = ctl_oe_q && (ph_q != lbm_pkg::PH_IDLE);
  assign hold_ack_o               = hack_q;
  assign rd_valid_o               = rdv_q;
  assign rd_data_o                = rdd_q;

endmodule

// File: verification/lbm_master_checker.sv
// Checker for lbm_master: strobe, latch and final-beat timing at its pins.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module lbm_master_checker (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Ready pins and hold answer
  input wire logic local_wait_ready_n_i,
  input wire logic memctl_ready_return_n_i,
  input wire logic hold_ack_o,
  // Output pins and enables
  input wire logic muxed_addr_data_bus_oe_o,
  input wire logic addr_strobe_n_o,
  input wire logic addr_strobe_n_oe_o,
  input wire logic addr_latch_en_o,
  input wire logic addr_latch_en_oe_o,
  input wire logic final_beat_n_o,
  input wire logic final_beat_n_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rdy_hi; // Neither ready pin active
  logic strb;   // Strobe driven low
  logic ltch;   // Latch enable driven high
  logic last;   // Final beat driven low
  assign rdy_hi = local_wait_ready_n_i & memctl_ready_return_n_i;
  assign strb   = addr_strobe_n_oe_o & ~addr_strobe_n_o;
  assign ltch   = addr_latch_en_oe_o & addr_latch_en_o;
  assign last   = final_beat_n_oe_o & ~final_beat_n_o;
  a_strobe_one_cycle: assert property (strb |=> !strb)
    else $error("strobe held past the address cycle");
  a_latch_marks_addr: assert property (ltch |-> strb)
    else $error("latch enable outside address cycle");
  a_latch_drops_data: assert property (ltch |=> !ltch)
    else $error("latch enable still high in data cycle");
  a_addr_on_bus: assert property (strb |-> muxed_addr_data_bus_oe_o)
    else $error("bus not driven in address cycle");
  a_hold_floats: assert property (hold_ack_o |-> !(muxed_addr_data_bus_oe_o ||
    addr_strobe_n_oe_o || addr_latch_en_oe_o || final_beat_n_oe_o))
    else $error("pin driven during hold");
  a_reset_quiet: assert property (disable iff (1'b0) (!rst_n_i && ce_i) |=>
    (!muxed_addr_data_bus_oe_o && addr_strobe_n_o && addr_strobe_n_oe_o &&
     !addr_latch_en_o && addr_latch_en_oe_o && !final_beat_n_oe_o))
    else $error("pin levels wrong in reset");
  a_final_waits: assert property ((last && rdy_hi && $past(rdy_hi) &&
    $past(rdy_hi, 2) && $past(rdy_hi, 3)) |=> last)
    else $error("final beat released without ready");
  a_final_ends: assert property ((last && !rdy_hi) |-> ##[1:5] !last)
    else $error("final beat not released after ready");
  c_access: cover property (strb ##1 last);
  c_wait: cover property (last ##1 last ##1 last);
  c_hold: cover property (hold_ack_o);
endmodule

bind lbm_master lbm_master_checker u_chk (.clk_i, .rst_n_i, .ce_i,
  .local_wait_ready_n_i, .memctl_ready_return_n_i, .hold_ack_o,
  .muxed_addr_data_bus_oe_o, .addr_strobe_n_o, .addr_strobe_n_oe_o,
  .addr_latch_en_o, .addr_latch_en_oe_o, .final_beat_n_o, .final_beat_n_oe_o);

// File: verification/lbm_mem_model.sv
// Memory-side model: one ready pulse per beat, read data per beat.
// Assumes strobe is already resolved to its pulled-up pin level.
`timescale 1ns/1ps
module lbm_mem_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Master pins
  input  wire logic [31:0] bus_o_i,
  input  wire logic        bus_oe_i,
  input  wire logic        strobe_n_i,
  input  wire logic [7:0]  wait_i,
  // Answers and observations
  output logic [31:0]      bus_i_o,
  output logic             lw_rdy_n_o,
  output logic             mc_rdy_n_o,
  output logic             busy_o,
  output logic [31:0]      cap_addr_o,
  output logic [31:0]      cap_wdata_o,
  output logic [7:0]       acc_cnt_o
);
  logic [2:0]  left; // Beats still to answer
  logic [7:0]  gap;  // Cycles to next pulse
  logic [1:0]  beat; // Beat index
  logic [2:0]  tail; // Read data hold after a pulse
  logic [31:0] rdat; // Read data of this beat
  assign busy_o  = (left != 3'h0);
  // Released bus shows read data during the tail, then the inverse so stale data never matches
  assign bus_i_o = bus_oe_i ? bus_o_i : ((tail != 3'h0) ? rdat : ~rdat);
  always @(posedge clk_i) begin
    lw_rdy_n_o <= 1'b1;
    mc_rdy_n_o <= 1'b1;
    if (tail != 3'h0)
      tail <= tail - 3'h1;
    if (!rst_n_i) begin
      left <= 3'h0;
      tail <= 3'h0;
      rdat <= 32'h0;
      acc_cnt_o <= 8'h0;
    end else if (!strobe_n_i) begin
      // Count is trusted: only core accesses reach this model
      cap_addr_o <= bus_o_i;
      left <= {1'b0, bus_o_i[1:0]} + 3'h1;
      gap <= wait_i;
      beat <= 2'h0;
      acc_cnt_o <= acc_cnt_o + 8'h1;
    end else if (left != 3'h0) begin
      if (gap != 8'h0) begin
        gap <= gap - 8'h1;
      end else begin
        // Alternate ready pins; spacing lets the synchroniser settle
        lw_rdy_n_o <= beat[0];
        mc_rdy_n_o <= ~beat[0];
        if (bus_oe_i)
          cap_wdata_o <= bus_o_i;
        rdat <= {cap_addr_o[31:4], 2'h0, beat};
        tail <= 3'h7;
        beat <= beat + 2'h1;
        left <= left - 3'h1;
        gap <= wait_i + 8'h4;
      end
    end
  end
endmodule

// File: verification/tb_top.sv
// Testbench for lbm_master against the memory-side model.
// Assumes 100 MHz clock and synchronous active-low reset.
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  lbm_pkg::lbm_req_s req = '0;
  logic hold_req = 1'b0;
  logic halt_req = 1'b0;
  logic [7:0] wait_c = 8'h0;
  logic lw_n, mc_n, req_ready, rd_valid, hold_ack, busy;
  logic bus_oe, strb_n, strb_oe, ltch, ltch_oe, fin_n, fin_oe, strb_w;
  logic [31:0] bus_i, bus_o, rd_data, cap_a, cap_w;
  logic [7:0] acc;
  logic [27:0] rd_hi; // Upper read address of the access
  logic [1:0] rd_idx; // Expected beat of next read
  int rd_n, bad_count, checked;
  always #5 clk_i = ~clk_i;
  assign strb_w = strb_oe ? strb_n : 1'b1; // Pulled up when floating
  lbm_master u_dut (.clk_i, .rst_n_i(rst_n), .ce_i(1'b1),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_i(req),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .local_wait_ready_n_i(lw_n), .memctl_ready_return_n_i(mc_n),
    .hold_req_i(hold_req), .halt_req_i(halt_req), .hold_ack_o(hold_ack),
    .muxed_addr_data_bus_i(bus_i), .muxed_addr_data_bus_o(bus_o),
    .muxed_addr_data_bus_oe_o(bus_oe), .addr_strobe_n_o(strb_n),
    .addr_strobe_n_oe_o(strb_oe), .addr_latch_en_o(ltch),
    .addr_latch_en_oe_o(ltch_oe), .final_beat_n_o(fin_n),
    .final_beat_n_oe_o(fin_oe));
  lbm_mem_model u_mem (.clk_i, .rst_n_i(rst_n), .bus_o_i(bus_o),
    .bus_oe_i(bus_oe), .strobe_n_i(strb_w), .wait_i(wait_c),
    .bus_i_o(bus_i), .lw_rdy_n_o(lw_n), .mc_rdy_n_o(mc_n), .busy_o(busy),
    .cap_addr_o(cap_a), .cap_wdata_o(cap_w), .acc_cnt_o(acc));
  task automatic tally_and_finish;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", what, e, g);
    end
  endtask
  // Bounded wait ran dry: count it and stop
  task automatic tmo(input int i, input int lim);
    if (i >= lim) begin
      chk("timeout", 32'h0, 32'h1);
      tally_and_finish;
    end
  endtask
  // Read beats must come back in order with the model's pattern
  always @(posedge clk_i) begin
    if (rd_valid === 1'b1) begin
      chk("read data", {rd_hi, 2'h0, rd_idx}, rd_data);
      rd_idx <= rd_idx + 2'h1;
      rd_n <= rd_n + 1;
    end
  end
  task automatic send(input logic [31:0] a, input logic w,
                      input logic [1:0] n, input logic [3:0] be,
                      input logic [31:0] d);
    int i;
    rd_hi = a[31:4];
    rd_idx = 2'h0;
    rd_n = 0;
    req_valid <= 1'b1;
    req <= '{a, w, n, be, d};
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (req_ready === 1'b1)
        break;
    end
    tmo(i, 50);
    req_valid <= 1'b0;
    // Let the access start, run out, and the read tail settle
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 400 && (busy === 1'b1 || fin_oe !== 1'b0); i++)
      @(posedge clk_i);
    tmo(i, 400);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic t_writes;
    send(32'h8000_0106, 1'b1, 2'h0, 4'hF, 32'hCAFE_F00D);
    chk("addr", 32'h8000_0104, cap_a);
    chk("wdata", 32'hCAFE_F00D, cap_w);
    send(32'h8000_0200, 1'b1, 2'h0, 4'h1, 32'hFFFF_FFAB);
    chk("lane 0", 32'h0000_00AB, cap_w);
    send(32'h8000_0300, 1'b1, 2'h0, 4'h6, 32'h1234_5678);
    chk("lanes 2:1", 32'h0034_5600, cap_w);
    $display("done writes");
  endtask
  task automatic t_bursts;
    for (int n = 0; n < 4; n++) begin
      wait_c <= 8'(2 * n);
      send(32'h4000_0010 + 32'(16 * n), 1'b0, 2'(n), 4'hF, 32'h0);
      chk("count", 32'(n), {30'h0, cap_a[1:0]});
      chk("beats", 32'(n + 1), 32'(rd_n));
    end
    wait_c <= 8'h0;
    $display("done bursts");
  endtask
  task automatic t_fifo_fill;
    int i, took;
    logic [7:0] a0;
    a0 = acc;
    took = 0;
    wait_c <= 8'h1E;
    req_valid <= 1'b1;
    req <= '{32'h5000_0000, 1'b1, 2'h0, 4'hF, 32'h0F0F_0F0F};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (req_ready !== 1'b1)
        break;
      took++;
    end
    req_valid <= 1'b0;
    chk("refused", 32'h0, {31'h0, req_ready});
    for (i = 0; i < 4000 && acc !== 8'(a0 + 8'(took)); i++)
      @(posedge clk_i);
    tmo(i, 4000);
    chk("drained", 32'(took), 32'(acc - a0));
    wait_c <= 8'h0;
    send(32'h5000_0100, 1'b1, 2'h0, 4'hF, 32'h0);
    $display("done fifo");
  endtask
  task automatic t_hold;
    int i;
    hold_req <= 1'b1;
    for (i = 0; i < 10 && hold_ack !== 1'b1; i++)
      @(posedge clk_i);
    tmo(i, 10);
    chk("hold enables", 32'h0, {28'h0, bus_oe, strb_oe, ltch_oe, fin_oe});
    hold_req <= 1'b0;
    repeat (6) @(posedge clk_i);
    $display("done hold");
  endtask
  task automatic t_halt(input logic w, input logic [31:0] a,
                        input logic [31:0] exp);
    send(a, w, 2'h2, 4'hF, 32'hA5A5_5A5C);
    halt_req <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("halt bus", exp, bus_o);
    chk("halt pins", 32'h1D, {27'h0, bus_oe, strb_w, strb_oe, ltch,
        fin_oe ? fin_n : 1'b1});
    halt_req <= 1'b0;
    repeat (6) @(posedge clk_i);
    $display("done halt");
  endtask
  initial begin
    bad_count = 0;
    checked = 0;
    rd_n = 0;
    repeat (5) @(posedge clk_i);
    chk("reset pins", 32'h1A, {26'h0, bus_oe, strb_n, strb_oe, ltch,
        ltch_oe, fin_oe});
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_writes();
    t_bursts();
    t_fifo_fill();
    t_hold();
    t_halt(1'b1, 32'h2000_0000, 32'hA5A5_5A5E);
    t_halt(1'b0, 32'h3000_0044, 32'h3000_0046);
    tally_and_finish();
  end
endmodule
